// ### design/cap_sense_tuning_control.sv
// Tuning, baseline filter and window control for the capacitive sensing engine
`timescale 1ns/1ps
`include "cst_defs.svh"
module cap_sense_tuning_control
  import cst_pkg::*;
(
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // Byte access from the serial port engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic win_end,
  // Ready line, open drain
  input wire logic rdy_in,
  output logic rdy_out,
  output logic rdy_oe_n,
  output logic comm_window,
  // Sensing engine
  input wire logic [`CH_N*`CW-1:0] counts,
  input wire logic [`CW-1:0] target,
  input wire logic conv_req,
  input wire logic conv_done,
  input wire logic [1:0] host_sens_mult,
  output logic convert_go,
  output logic tune_start,
  output logic tune_busy,
  output logic tune_partial,
  output logic [1:0] tune_sens_mult,
  output logic clear_events,
  output logic [`CH_N*`CW-1:0] long_term_average,
  output logic [`CH_N*`CW-1:0] ref_val
);
  // ****************************************
  // Control byte
  // ****************************************
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] rdata_q;
  tune_state_t st_q;
  logic [4:0] runs_q;
  logic start_q, partial_q, clr_q, win_q;
  logic [1:0] mult_q;
  logic [2:0] rdy_sync_q;
  logic rdy_lvl_q, oe_n_q;
  logic [2:0] drv_hist_q;
  logic [`CW-1:0] lta_q [`CH_N];
  logic [`CW-1:0] ref_q [`CH_N];
  logic [`CH_N-1:0] oob;

  wire wr_hit = ce && reg_wr && (reg_addr == `CTRL_ADDR);
  wire halt = ctrl_q[`BIT_HALT];
  wire idle = (st_q == ST_IDLE);
  wire any_oob = |oob;
  wire [`CW-1:0] band = ctrl_q[`BIT_WIDE_BAND] ? (target >> 2) : (target >> 3);

  // Halt keeps requests pending rather than dropping them
  wire force_fire = ce && idle && ctrl_q[`BIT_FORCE] && !halt;
  wire reseed_fire = ce && ctrl_q[`BIT_RESEED] && !halt;
  wire auto_fire = ce && idle && conv_done && !ctrl_q[`BIT_RETUNE_DIS] && any_oob && !halt;
  wire reseed_tune = reseed_fire && idle && any_oob;
  wire start_fire = force_fire || auto_fire || reseed_tune;
  wire [4:0] run_lim = ctrl_q[`BIT_PARTIAL] ? `RUNS_PARTIAL : `RUNS_FULL;
  wire tune_done = ce && !idle && conv_done && (runs_q == run_lim - 5'h01);
  // Own drive of the pin echoes through the stages; only a host pull counts
  wire pin_free = !win_q && !drv_hist_q[1] && !drv_hist_q[2];
  wire rdy_fall = rdy_lvl_q && (rdy_sync_q[2] == rdy_sync_q[1]) && !rdy_sync_q[1] && pin_free;
  wire win_open = rdy_fall || (conv_done && (idle || ctrl_q[`BIT_DEBUG_WIN]));

  // Hardware clear of a self-clearing bit loses to a fresh write
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (force_fire)
      ctrl_d[`BIT_FORCE] = 1'b0;
    if (reseed_fire)
      ctrl_d[`BIT_RESEED] = 1'b0;
    if (wr_hit)
      ctrl_d = reg_wdata | (ctrl_d & 8'h18 & ctrl_q);
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q <= `CTRL_RESET;
      rdata_q <= 8'h00;
    end
    else if (ce)
    begin
      ctrl_q <= ctrl_d;
      if (reg_rd)
        rdata_q <= (reg_addr == `CTRL_ADDR) ? ctrl_q : 8'h00;
    end
  end

  // ****************************************
  // Tuning sequence
  // ****************************************
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= ST_IDLE;
      runs_q <= 5'h00;
      start_q <= 1'b0;
      partial_q <= 1'b0;
      mult_q <= 2'h0;
      clr_q <= 1'b0;
    end
    else if (ce)
    begin
      start_q <= start_fire;
      clr_q <= reseed_fire;
      case (st_q)
        ST_IDLE:
        begin
          runs_q <= 5'h00;
          if (start_fire)
          begin
            st_q <= ST_TUNE;
            partial_q <= ctrl_q[`BIT_PARTIAL];
            mult_q <= host_sens_mult;
          end
        end
        ST_TUNE:
        begin
          if (tune_done)
            st_q <= ST_IDLE;
          else if (conv_done)
            runs_q <= runs_q + 5'h01;
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Per channel band check and filters
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < `CH_N; i++)
    begin : g_ch
      wire [`CW-1:0] cnt = counts[i*`CW +: `CW];
      wire [`CW-1:0] diff = (cnt > target) ? (cnt - target) : (target - cnt);
      wire [`CW-1:0] seed = (i == 0) ? (cnt - `SEED_OFFSET) : (cnt + `SEED_OFFSET);
      assign oob[i] = diff > band;
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          lta_q[i] <= 16'h0000;
          ref_q[i] <= 16'h0000;
        end
        else if (ce && !halt)
        begin
          if (reseed_fire)
            lta_q[i] <= seed;
          else if (conv_done && lta_q[i] < cnt)
            lta_q[i] <= lta_q[i] + 16'h0001;
          else if (conv_done && lta_q[i] > cnt)
            lta_q[i] <= lta_q[i] - 16'h0001;
          if (reseed_fire || tune_done)
            ref_q[i] <= cnt;
        end
      end
      assign long_term_average[i*`CW +: `CW] = lta_q[i];
      assign ref_val[i*`CW +: `CW] = ref_q[i];
    end
  endgenerate

  // ****************************************
  // Ready line and windows
  // ****************************************
  // Level changes only once two late stages agree
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdy_sync_q <= 3'b111;
      rdy_lvl_q <= 1'b1;
      win_q <= 1'b0;
      oe_n_q <= 1'b1;
      drv_hist_q <= 3'b000;
    end
    else if (ce)
    begin
      rdy_sync_q <= {rdy_sync_q[1:0], rdy_in};
      drv_hist_q <= {drv_hist_q[1:0], win_q};
      if (rdy_sync_q[2] == rdy_sync_q[1])
        rdy_lvl_q <= rdy_sync_q[1];
      // A fresh window request outranks a session end in the same cycle
      if (win_open)
      begin
        win_q <= 1'b1;
        oe_n_q <= 1'b0;
      end
      else if (win_end)
      begin
        win_q <= 1'b0;
        oe_n_q <= 1'b1;
      end
    end
  end

  settle_timer u_settle (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ce(ce),
    .start(conv_req),
    .long_sel(ctrl_q[`BIT_STABLE]),
    .done(convert_go)
  );

  assign reg_rdata = rdata_q;
  assign rdy_out = 1'b0;
  assign rdy_oe_n = oe_n_q;
  assign comm_window = win_q;
  assign tune_start = start_q;
  // Busy is the low state bit, so the output leaves a flop directly
  assign tune_busy = st_q[0];
  assign tune_partial = partial_q;
  assign tune_sens_mult = mult_q;
  assign clear_events = clr_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_reseed_req;
    ce && ctrl_q[`BIT_RESEED] && !halt;
  endsequence

  a_auto_retune_go: assert property (auto_fire |=> tune_start && tune_busy)
    else $error("auto retune not started");
  a_disable_blocks_auto: assert property (ce && idle && ctrl_q[`BIT_RETUNE_DIS]
    && !ctrl_q[`BIT_FORCE] && !ctrl_q[`BIT_RESEED] |=> !tune_start)
    else $error("retune started while disabled");
  a_partial_latched: assert property (tune_start |-> tune_partial == $past(ctrl_q[`BIT_PARTIAL])
    && tune_sens_mult == $past(host_sens_mult))
    else $error("partial selection not taken");
  a_band_ch0: assert property (ce && idle && conv_done && !halt && !ctrl_q[`BIT_RETUNE_DIS]
    && ((counts[`CW-1:0] - target) > (ctrl_q[`BIT_WIDE_BAND] ? target >> 2 : target >> 3))
    && counts[`CW-1:0] > target |=> tune_start)
    else $error("band check wrong");
  a_force_self_clear: assert property (force_fire && !wr_hit |=> tune_start
    && !ctrl_q[`BIT_FORCE])
    else $error("forced retune not handled");
  a_reseed_seed: assert property (s_reseed_req |=> lta_q[0] == $past(counts[`CW-1:0])
    - `SEED_OFFSET && ref_q[1] == $past(counts[2*`CW-1:`CW]))
    else $error("reseed value wrong");
  a_reseed_clears: assert property (s_reseed_req ##0 (!wr_hit) |=> clear_events
    && !ctrl_q[`BIT_RESEED])
    else $error("reseed did not clear");
  a_reseed_retune: assert property (s_reseed_req ##0 (idle && any_oob) |=> tune_start)
    else $error("reseed out of band without retune");
  a_no_tune_window: assert property (ce && !idle && !ctrl_q[`BIT_DEBUG_WIN] && !rdy_fall
    && !win_q |=> !comm_window)
    else $error("window opened during tuning");
  a_halt_freeze: assert property (ce && halt |=> $stable(lta_q[0]) && $stable(ref_q[0])
    && !tune_start)
    else $error("filters moved while halted");
  a_rdy_grant: assert property (ce && rdy_fall |=> comm_window && !rdy_oe_n)
    else $error("ready request not granted");
endmodule

// ### design/cst_defs.svh
// Constants for the capacitive sensing tuning control block
`ifndef CST_DEFS_SVH
`define CST_DEFS_SVH

// ****************************************
// Register map and field positions
// ****************************************
`define CTRL_ADDR 8'h80
`define CTRL_RESET 8'h00
`define BIT_RETUNE_DIS 0
`define BIT_PARTIAL 1
`define BIT_WIDE_BAND 2
`define BIT_FORCE 3
`define BIT_RESEED 4
`define BIT_DEBUG_WIN 5
`define BIT_STABLE 6
`define BIT_HALT 7

// ****************************************
// Sizes and counts
// ****************************************
`define CH_N 7
`define CW 16
`define SEED_OFFSET 16'h0008
`define RUNS_FULL 5'h10
`define RUNS_PARTIAL 5'h04

// ****************************************
// Settling times
// ****************************************
`define CLK_MHZ 40
`define SETTLE_SHORT_NS 500
`define SETTLE_LONG_NS 2000
`define SETTLE_SHORT_CYC ((`SETTLE_SHORT_NS * `CLK_MHZ + 999) / 1000)
`define SETTLE_LONG_CYC ((`SETTLE_LONG_NS * `CLK_MHZ + 999) / 1000)

`endif

// ### design/cst_pkg.sv
// Types for the capacitive sensing tuning control block
package cst_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TUNE = 2'b01
  } tune_state_t;
endpackage

// ### design/settle_timer.sv
// Analogue settling delay ahead of each conversion
`timescale 1ns/1ps
`include "cst_defs.svh"
module settle_timer
  import cst_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // Control
  input wire logic start,
  input wire logic long_sel,
  output logic done
);
  localparam logic [7:0] SHORT_CYC = 8'(`SETTLE_SHORT_CYC);
  localparam logic [7:0] LONG_CYC = 8'(`SETTLE_LONG_CYC);

  logic [7:0] cnt_q;
  logic busy_q;
  logic done_q;
  wire last = busy_q && (cnt_q == 8'h01);

  // Longer wait costs current but steadies the regulator
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q <= 8'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (ce)
    begin
      done_q <= last;
      if (start && !busy_q)
      begin
        cnt_q <= long_sel ? LONG_CYC : SHORT_CYC;
        busy_q <= 1'b1;
      end
      else if (busy_q)
      begin
        cnt_q <= cnt_q - 8'h01;
        busy_q <= !last;
      end
    end
  end

  assign done = done_q;
endmodule

// ### verif/host_port.sv
// Host model: byte access and the open-drain ready line
`timescale 1ns/1ps
module host_port (
  // Clock
  input wire logic sys_clk,
  // Byte access
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  output logic win_end,
  // Ready line and option
  output logic rdy_in,
  input wire logic rdy_out,
  input wire logic rdy_oe_n,
  output logic [1:0] host_sens_mult
);
  // ****
  // Pin and tasks
  // ****
  logic pull_n = 1'b1;
  int slow = 0;
  // Pulled up; low while either side drives it
  assign rdy_in = pull_n & (rdy_oe_n | rdy_out);
  initial
  begin
    {reg_addr, reg_wr, reg_wdata, reg_rd, win_end} = '0;
    host_sens_mult = 2'h0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    reg_wdata = ~d;
    step(1 + slow);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    step(1 + slow);
    d = reg_rdata;
  endtask
  task automatic pull;
    pull_n = 1'b0;
    step(8);
    pull_n = 1'b1;
  endtask
  task automatic close;
    win_end = 1'b1;
    step(1);
    win_end = 1'b0;
    step(1);
  endtask
endmodule

// ### verif/cap_sense_tuning_control_bench.sv
// Self-checking bench for the tuning control block
`timescale 1ns/1ps
`include "cst_defs.svh"
module cap_sense_tuning_control_bench;
  // ****
  // Harness
  // ****
  localparam int W = `CH_N * `CW;
  localparam int CHKW = W + 48;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic conv_req = 1'b0;
  logic conv_done = 1'b0;
  logic [W-1:0] counts = '0;
  logic [15:0] target = 16'h0320;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic reg_wr, reg_rd, win_end, rdy_in, rdy_out, rdy_oe_n, comm_window;
  logic convert_go, tune_start, tune_busy, tune_partial, clear_events;
  logic [1:0] host_sens_mult, tune_sens_mult;
  logic [W-1:0] long_term_average, ref_val, keep;
  wire [3:0] flg = {comm_window, convert_go, clear_events, tune_start};
  int fail_count = 0;
  int cmp_count = 0;
  int t, t1;
  logic [23:0] rows [8] = '{24'h80_0101, 24'h80_0202, 24'h80_0404, 24'h80_2020,
    24'h80_4040, 24'h80_8080, 24'h81_ff00, 24'h80_0000};
  cap_sense_tuning_control DUT (.sys_clk, .rstn, .ce, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata, .win_end, .rdy_in, .rdy_out, .rdy_oe_n,
    .comm_window, .counts, .target, .conv_req, .conv_done, .host_sens_mult,
    .convert_go, .tune_start, .tune_busy, .tune_partial, .tune_sens_mult,
    .clear_events, .long_term_average, .ref_val);
  host_port host (.sys_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .win_end, .rdy_in, .rdy_out, .rdy_oe_n, .host_sens_mult);
  initial forever #12.5 sys_clk = ~sys_clk;
  // ****
  // Tasks
  // ****
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [CHKW-1:0] s, input logic [CHKW-1:0] e);
    cmp_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("ERROR %0t: saw %0h want %0h", $time, s, e);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Bounded wait on one flag; e says whether it should show
  task automatic wt(input int i, input int n, input logic e);
    t = 0;
    while (flg[i] !== 1'b1 && t < n)
    begin
      step(1);
      t++;
    end
    chk(t < n, e);
    if (e && t >= n)
      stop_test();
  endtask
  task automatic cd(input int n);
    repeat (n)
    begin
      step(1);
      conv_done = 1'b1;
      step(1);
      conv_done = 1'b0;
    end
  endtask
  task automatic setc(input logic [15:0] b, input int ch, input logic [15:0] o);
    counts = {`CH_N{b}};
    counts[ch*`CW +: `CW] = o;
  endtask
  task automatic settle;
    conv_req = 1'b1;
    step(1);
    conv_req = 1'b0;
    wt(2, 200, 1'b1);
  endtask
  task automatic fin(input string s);
    $display("%s done, mismatches %0d", s, fail_count);
  endtask
  // ****
  // Sequence
  // ****
  initial
  begin
    setc(16'h0320, 0, 16'h03b6);
    step(4);
    rstn = 1'b1;
    step(1);
    chk({reg_rdata, rdy_out, rdy_oe_n, comm_window, tune_busy, long_term_average},
      {8'h00, 4'b0100, W'(0)});
    fin("reset");
    host.slow = 1;
    foreach (rows[k])
    begin
      host.wr(rows[k][23:16], rows[k][15:8]);
      host.rd(rows[k][23:16], v);
      chk(v, rows[k][7:0]);
    end
    host.slow = 0;
    fin("registers");
    host.wr(8'h80, 8'h04);
    cd(1);
    wt(0, 4, 1'b0);
    host.wr(8'h80, 8'h00);
    cd(1);
    wt(0, 4, 1'b1);
    cd(16);
    step(2);
    chk(tune_busy, 0);
    fin("band");
    setc(16'h0320, 0, 16'h0320);
    host.close();
    host.wr(8'h80, 8'h09);
    wt(0, 6, 1'b1);
    host.rd(8'h80, v);
    chk(v, 8'h01);
    host.close();
    cd(1);
    chk(comm_window, 0);
    host.pull();
    wt(3, 12, 1'b1);
    chk(rdy_oe_n, 0);
    host.close();
    host.wr(8'h80, 8'h21);
    cd(1);
    wt(3, 3, 1'b1);
    cd(14);
    step(2);
    chk({tune_busy, ref_val}, {1'b0, counts});
    fin("forced");
    host.host_sens_mult = 2'h2;
    host.wr(8'h80, 8'h0b);
    wt(0, 6, 1'b1);
    chk({tune_partial, tune_sens_mult}, 3'b110);
    cd(4);
    step(2);
    chk(tune_busy, 0);
    // Enable low: a write must not land
    ce = 1'b0;
    host.wr(8'h80, 8'h08);
    ce = 1'b1;
    host.rd(8'h80, v);
    chk({v, tune_busy}, {8'h03, 1'b0});
    fin("partial");
    target = 16'h03e8;
    setc(16'h03e8, 0, 16'h03e8);
    host.wr(8'h80, 8'h10);
    wt(1, 6, 1'b1);
    step(1);
    chk({long_term_average[31:0], ref_val}, {32'h03f0_03e0, counts});
    wt(0, 4, 1'b0);
    host.rd(8'h80, v);
    chk(v, 8'h00);
    cd(3);
    chk(long_term_average[31:16], 16'h03ed);
    setc(16'h03e8, 3, 16'h04b0);
    host.wr(8'h80, 8'h10);
    wt(0, 8, 1'b1);
    cd(16);
    step(2);
    fin("reseed");
    keep = long_term_average;
    host.wr(8'h80, 8'h91);
    wt(1, 8, 1'b0);
    host.rd(8'h80, v);
    chk(v, 8'h91);
    cd(2);
    chk(long_term_average, keep);
    host.wr(8'h80, 8'h01);
    wt(1, 6, 1'b1);
    fin("halt");
    settle();
    t1 = t;
    chk(t1, `SETTLE_SHORT_CYC);
    host.wr(8'h80, 8'h41);
    settle();
    chk(t - t1, `SETTLE_LONG_CYC - `SETTLE_SHORT_CYC);
    fin("settle");
    rstn = 1'b0;
    step(2);
    rstn = 1'b1;
    step(1);
    host.rd(8'h80, v);
    chk({v, tune_busy, comm_window, rdy_oe_n}, {8'h00, 3'b001});
    fin("reset again");
    stop_test();
  end
endmodule
